// file: design/arm_defs.svh
`ifndef ADCRM_DEFS_SVH
`define ADCRM_DEFS_SVH

// register byte offsets
`define ADCRM_OFF_SET0     12'h000
`define ADCRM_OFF_SET1     12'h004
`define ADCRM_OFF_CMP0     12'h008
`define ADCRM_OFF_CMP1     12'h00c
`define ADCRM_OFF_STATUS   12'h010
`define ADCRM_OFF_MASK     12'h014
`define ADCRM_OFF_RESULT   12'h018

// setting register fields
`define ADCRM_CNT_MSB      11
`define ADCRM_CNT_LSB      8
`define ADCRM_ON_BIT       7
`define ADCRM_DIR_BIT      4
`define ADCRM_SEL_MSB      3
`define ADCRM_SEL_LSB      0

// compare and result value field
`define ADCRM_VAL_MSB      15
`define ADCRM_VAL_LSB      4

// reset values
`define ADCRM_CNT_RST      4'h0
`define ADCRM_ON_RST       1'b0
`define ADCRM_DIR_RST      1'b0
`define ADCRM_SEL_RST      4'h0
`define ADCRM_VAL_RST      12'h000
`define ADCRM_STATUS_RST   2'h0
`define ADCRM_MASK_RST     2'h0

// number of result registers that may be selected
`define ADCRM_NUM_RESULTS  12

`endif

// file: design/arm_pkg.sv
package adcrm_pkg;

  // comparison direction of one monitor
  typedef enum logic {
    ADCRM_DIR_GE = 1'b0,
    ADCRM_DIR_LE = 1'b1
  } adcrm_dir_t;

endpackage

// file: design/arm_monitor.sv
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "arm_defs.svh"

// result monitor: comparators watch the converter's result file
// and raise an interrupt once a run of matches completes;
// software reaches the settings over the peripheral bus
module adcrm_monitor #(
  parameter int NUM_MON = 2,
  parameter int CNT_W   = 4
) (
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [11:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic [11:0]          RESULT_STORED,
  input  wire logic [191:0]         RESULT_DATA,
  output logic      [NUM_MON-1:0]   MONITOR_IRQ,
  output logic                      IRQ
);

  // bus decode strobes
  logic                  wr_en;
  logic                  rd_en;
  logic                  wr_st;
  logic                  wr_mask;
  logic                  addr_ok;
  // next-value terms for the registered bus outputs and the summary interrupt
  logic [31:0]           next_rdata;
  logic                  next_ready;
  logic                  next_err;
  logic                  next_irq;

  // converter inputs: two stages before any logic reads them
  logic [11:0]           stored_s1;
  logic [11:0]           stored_s2;
  logic [11:0]           stored_d;
  logic [11:0]           stored_rise;
  logic [191:0]          data_s1;
  logic [191:0]          data_s2;

  // per-monitor state gathered for reads and the interrupt path
  wire  [11:0]           setting_rd [NUM_MON];
  wire  [11:0]           cmp_rd     [NUM_MON];
  wire  [NUM_MON-1:0]    fixed_ev;
  wire  [NUM_MON-1:0]    outcome;
  logic [NUM_MON-1:0]    status;
  logic [NUM_MON-1:0]    mask;
  logic [NUM_MON-1:0]    clr_bits;
  logic [NUM_MON-1:0]    next_status;

  // a transfer completes in its first access cycle, so writes land
  // at the access edge and reads are captured during setup
  assign wr_en   = PSEL & PENABLE & PWRITE;
  assign rd_en   = PSEL & ~PENABLE & ~PWRITE;
  assign wr_st   = wr_en && (PADDR == `ADCRM_OFF_STATUS);
  assign wr_mask = wr_en && (PADDR == `ADCRM_OFF_MASK);

  // result-stored levels cross from the converter: two flops each
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      stored_s1 <= 12'h000;
      stored_s2 <= 12'h000;
    end else begin
      stored_s1 <= RESULT_STORED;
      stored_s2 <= stored_s1;
    end
  end

  // result words follow the same two stages; the converter keeps a
  // word still around its flag edge, so the word is settled by the
  // time the synchronised flag is seen
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      data_s1 <= 192'h0;
      data_s2 <= 192'h0;
    end else begin
      data_s1 <= RESULT_DATA;
      data_s2 <= data_s1;
    end
  end

  // delayed copy for edge detection; reset matches the idle low
  // level so no false edge follows reset
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      stored_d <= 12'h000;
    end else begin
      stored_d <= stored_s2;
    end
  end

  // a rising flag means a fresh result in that register; a flag
  // held high counts once, so it must fall before the next result
  assign stored_rise = stored_s2 & ~stored_d;

  // one monitor per generate entry, identical and independent
  genvar m;
  generate
    for (m = 0; m < NUM_MON; m++) begin : g_mon
      logic [3:0]            match_count_sel;
      logic                  monitor_on;
      adcrm_pkg::adcrm_dir_t compare_direction;
      logic [3:0]            result_select;
      logic [11:0]           compare_value;
      logic [CNT_W-1:0]      run_count;
      logic                  fixed;
      logic                  result;
      logic                  wr_set;
      logic                  wr_cmp;
      logic                  sel_ok;
      logic [3:0]            word_idx;
      logic                  new_result;
      logic [11:0]           sample;
      logic                  hit;
      logic                  last_hit;

      // each monitor owns one setting and one compare word
      assign wr_set = wr_en &&
                      (PADDR == (`ADCRM_OFF_SET0 + 12'(m * 4)));
      assign wr_cmp = wr_en &&
                      (PADDR == (`ADCRM_OFF_CMP0 + 12'(m * 4)));

      // setting fields; bits 6..5 and 31..12 are not stored at all
      always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          match_count_sel   <= `ADCRM_CNT_RST;
          monitor_on        <= `ADCRM_ON_RST;
          compare_direction <= adcrm_pkg::adcrm_dir_t'(`ADCRM_DIR_RST);
          result_select     <= `ADCRM_SEL_RST;
        end else if (wr_set) begin
          match_count_sel   <= PWDATA[`ADCRM_CNT_MSB:`ADCRM_CNT_LSB];
          monitor_on        <= PWDATA[`ADCRM_ON_BIT];
          compare_direction <=
            adcrm_pkg::adcrm_dir_t'(PWDATA[`ADCRM_DIR_BIT]);
          result_select     <= PWDATA[`ADCRM_SEL_MSB:`ADCRM_SEL_LSB];
        end
      end

      // compare value: only the 12-bit field is kept
      always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          compare_value <= `ADCRM_VAL_RST;
        end else if (wr_cmp) begin
          compare_value <= PWDATA[`ADCRM_VAL_MSB:`ADCRM_VAL_LSB];
        end
      end

      // codes above eleven select no register, so no comparison runs;
      // the index is pinned to zero then to keep the slice in range
      assign sel_ok     = result_select < 4'(`ADCRM_NUM_RESULTS);
      assign word_idx   = sel_ok ? result_select : 4'h0;
      // a result stored while the monitor is off is never counted
      assign new_result = sel_ok && stored_rise[word_idx];

      // the 12-bit value lives in bits 15..4 of each result word
      assign sample = data_s2[word_idx*16 + `ADCRM_VAL_LSB +: 12];

      // both bounds are inclusive, so equal values always match
      always_comb begin
        if (compare_direction == adcrm_pkg::ADCRM_DIR_LE) begin
          hit = (sample <= compare_value);
        end else begin
          hit = (sample >= compare_value);
        end
      end

      // the count field is N for N+1 comparisons, so the run is
      // complete when N matches have already been counted
      assign last_hit = (run_count == CNT_W'(match_count_sel));

      // consecutive-match counter; a miss or disabling restarts it
      always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          run_count <= '0;
        end else if (!monitor_on) begin
          run_count <= '0;
        end else if (new_result) begin
          if (!hit || last_hit) begin
            run_count <= '0;
          end else begin
            run_count <= run_count + 1'b1;
          end
        end
      end

      // one-cycle event when the outcome becomes fixed
      always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          fixed <= 1'b0;
        end else begin
          fixed <= monitor_on && new_result && hit && last_hit;
        end
      end

      // last outcome: set on a fixed run, cleared by a failed match;
      // it is kept while the monitor is off so software can read it
      always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          result <= 1'b0;
        end else if (monitor_on && new_result) begin
          if (!hit) begin
            result <= 1'b0;
          end else if (last_hit) begin
            result <= 1'b1;
          end
        end
      end

      // gather this monitor's state for the shared logic
      assign setting_rd[m] = {match_count_sel, monitor_on, 2'h0,
                              compare_direction, result_select};
      assign cmp_rd[m]     = compare_value;
      assign fixed_ev[m]   = fixed;
      assign outcome[m]    = result;
    end
  endgenerate

  // dedicated interrupt pulse per monitor once its outcome is fixed
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      MONITOR_IRQ <= '0;
    end else begin
      MONITOR_IRQ <= fixed_ev;
    end
  end

  // write-one-to-clear bits from a status write
  assign clr_bits = wr_st ? PWDATA[NUM_MON-1:0] : '0;

  // sticky status: a new event wins over a same-cycle clear, so an
  // event is never lost to a clear that races it
  assign next_status = fixed_ev | (status & ~clr_bits);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      status <= NUM_MON'(`ADCRM_STATUS_RST);
    end else begin
      status <= next_status;
    end
  end

  // mask register: one enable per monitor for the summary line;
  // masking hides a status bit from the line but never clears it
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mask <= NUM_MON'(`ADCRM_MASK_RST);
    end else if (wr_mask) begin
      mask <= PWDATA[NUM_MON-1:0];
    end
  end

  // summary level: high while any unmasked status bit is set;
  // registered, so it trails the status bit by one clock
  assign next_irq = |(status & mask);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= next_irq;
    end
  end

  // read decode; unmapped offsets read zero and flag an error;
  // the setting word rebuilds its spare bits as zero
  always_comb begin
    next_rdata = 32'h0;
    addr_ok    = 1'b1;
    case (PADDR)
      `ADCRM_OFF_SET0: begin
        next_rdata = {20'h0, setting_rd[0]};
      end
      `ADCRM_OFF_SET1: begin
        next_rdata = {20'h0, setting_rd[1]};
      end
      `ADCRM_OFF_CMP0: begin
        next_rdata = {16'h0, cmp_rd[0], 4'h0};
      end
      `ADCRM_OFF_CMP1: begin
        next_rdata = {16'h0, cmp_rd[1], 4'h0};
      end
      `ADCRM_OFF_STATUS: begin
        next_rdata = 32'(status);
      end
      `ADCRM_OFF_MASK: begin
        next_rdata = 32'(mask);
      end
      `ADCRM_OFF_RESULT: begin
        next_rdata = 32'(outcome);
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // read data is captured in setup so it comes from a flop and
  // holds until the next read
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h0;
    end else if (rd_en) begin
      PRDATA <= next_rdata;
    end
  end

  // zero wait states: ready follows every setup cycle
  assign next_ready = PSEL & ~PENABLE;
  assign next_err   = PSEL & ~PENABLE & ~addr_ok;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= next_ready;
    end
  end

  // error pairs with ready so it only stands in the access cycle;
  // writes to an unmapped offset change nothing
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= next_err;
    end
  end

endmodule

// file: testbench/adcrm_checker.sv
`timescale 1ns/100ps
// watches bus timing and the interrupt outputs
module adcrm_checker #(
  parameter int NUM_MON = 2
) (
  input wire logic               CLK,
  input wire logic               RESET,
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic               PWRITE,
  input wire logic [11:0]        PADDR,
  input wire logic [31:0]        PRDATA,
  input wire logic               PREADY,
  input wire logic               PSLVERR,
  input wire logic [NUM_MON-1:0] MONITOR_IRQ,
  input wire logic               IRQ
);
  // reads and writes complete at the access edge
  wire rd = PSEL && PENABLE && PREADY && !PWRITE;
  wire wr = PSEL && PENABLE && PREADY && PWRITE;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  ready_timely_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held");
  err_access_a: assert property (PSLVERR |-> PREADY) else $error("stray error");
  err_data_a: assert property (PSLVERR && rd |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  cmp_zero_a: assert property (rd && PADDR[11:3] == 9'h001 |->
    PRDATA[31:16] == 16'h0 && PRDATA[3:0] == 4'h0) else $error("cmp spare");
  set_zero_a: assert property (rd && PADDR[11:3] == 9'h000 |->
    PRDATA[31:12] == 20'h0 && PRDATA[6:5] == 2'h0) else $error("set spare");
  irq_pulse_a: assert property ((MONITOR_IRQ & $past(MONITOR_IRQ)) == '0)
    else $error("monitor irq longer than one cycle");
  // sticky status: the line only drops after software writes
  irq_drop_a: assert property ($fell(IRQ) |-> $past(wr, 2))
    else $error("irq dropped by itself");
endmodule
bind adcrm_monitor adcrm_checker #(.NUM_MON(NUM_MON)) adcrm_checker_i (
  .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .MONITOR_IRQ(MONITOR_IRQ), .IRQ(IRQ));

// file: testbench/adcrm_results.sv
`timescale 1ns/100ps
// converter result file: word settles an edge before its flag rises
module adcrm_results (
  input  wire logic    clk,
  output logic [11:0]  stored,
  output logic [191:0] data
);
  initial begin
    stored = 12'h000;
    data = '0;
  end
  // spare low bits carry noise so only bits 15..4 may count
  task automatic put(input int k, input logic [11:0] v);
    @(posedge clk);
    data[16*k +: 16] <= {v, 4'($urandom)};
    @(posedge clk);
    stored[k] <= 1'b1;
    repeat (6) @(posedge clk);
    stored[k] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/100ps
`include "arm_defs.svh"
module tb;
  logic         clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic         pwrite = 1'b0, pready, pslverr, irq, d;
  logic [11:0]  paddr = 12'h000, stored, c;
  logic [31:0]  pwdata = 32'h0, prdata, w, rq[$];
  logic [1:0]   mon_irq, iq[$];
  logic [191:0] rdata;
  int           errors = 0, tests_run = 0, k, m, n;
  // 100 ns period
  always #50 clk = ~clk;
  adcrm_monitor adcrm_monitor_i (.CLK(clk), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
    .RESULT_STORED(stored), .RESULT_DATA(rdata), .MONITOR_IRQ(mon_irq));
  adcrm_results adcrm_results_i (.clk(clk), .stored(stored), .data(rdata));
  task automatic chk(input string s, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one transfer, held until ready; a read leaves its note
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, exp);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
    if (!wr) rq.push_back(exp);
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, penable} <= 2'h0;
  endtask
  // oldest note against each finished read or monitor pulse
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      chk("pslverr", 32'(pslverr), 32'(paddr > `ADCRM_OFF_RESULT));
      if (!pwrite) chk("read", prdata, rq.pop_front());
    end
    if (mon_irq != 2'h0)
      chk("monitor_irq", 32'(mon_irq), iq.size() ? 32'(iq.pop_front()) : 0);
  end
  // j even hits the compare value exactly, odd one step inside
  task automatic hit(input int j);
    adcrm_results_i.put(k, d ? c - 12'(j % 2) : c + 12'(j % 2));
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(negedge clk);
    chk("irq", 32'(irq), 32'(e));
  endtask
  initial begin
    w = $urandom(32'h884e);
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 32; a += 4) apb(0, 12'(a), 0, 0);
    apb(1, `ADCRM_OFF_MASK, 3, 0);
    // program, a run one short, a foreign hit, a miss, then n+1 hits
    for (int i = 0; i < 8; i++) begin
      m = i % 2;
      d = i[1];
      n = i == 7 ? 15 : $urandom % 3;
      k = $urandom % 12;
      c = 12'h400 + 12'($urandom % 2048);
      w = $urandom;
      apb(1, 12'(8 + 4 * m), {w[31:16], c, w[3:0]}, 0);
      apb(0, 12'(8 + 4 * m), 0, {16'h0, c, 4'h0});
      apb(1, 12'(4 * m), {w[31:12], 4'(n), 1'b1, w[6:5], d, 4'(k)}, 0);
      apb(0, 12'(4 * m), 0, {20'h0, 4'(n), 3'h4, d, 4'(k)});
      for (int j = 0; j < n; j++) hit(j);
      adcrm_results_i.put(k ^ 1, c);
      adcrm_results_i.put(k, d ? c + 12'h1 : c - 12'h1);
      for (int j = 0; j < n; j++) hit(j);
      iq.push_back(2'(1 << m));
      hit(n);
      irq_is(1);
      apb(0, `ADCRM_OFF_RESULT, 0, i ? 3 : 1);
      apb(1, 12'(4 * m), 0, 0);
    end
    hit(0);
    // mask hides a set bit, write-one clears only its own bit
    apb(0, `ADCRM_OFF_STATUS, 0, 3);
    apb(1, `ADCRM_OFF_MASK, 0, 0);
    irq_is(0);
    apb(1, `ADCRM_OFF_MASK, 2, 0);
    irq_is(1);
    apb(1, `ADCRM_OFF_STATUS, 2, 0);
    apb(0, `ADCRM_OFF_STATUS, 0, 1);
    irq_is(0);
    apb(1, 12'h01c, 32'hffff_ffff, 0);
    apb(0, 12'h01c, 0, 0);
    chk("pending", 32'(iq.size()), 0);
    wrap_up;
  end
  // hang guard, well past the thousand or so cycles needed
  initial begin
    #4_000_000;
    errors++;
    wrap_up;
  end
endmodule
